// ===== design/supply_seq_map.svh
`ifndef SUPPLY_SEQ_MAP_SVH
`define SUPPLY_SEQ_MAP_SVH

// Time base.
`define CLK_HZ 10000000
`define TICK_MS 1
`define CYC_PER_MS (`CLK_HZ / 1000 * `TICK_MS)

// Delays in milliseconds.
`define ACOK_ON_START_MS 11'd1000
`define ACOK_ON_DIP_MS 11'd50
`define ACOK_OFF_MS 11'd2
`define MAIN_ON_DLY_MS 11'd15
`define OFF_REST_MS 11'd1100
`define AC_MAIN_PRE_MS 11'd6
`define AC_SB_HOLD_MS 11'd16
`define PG_ON_MS 11'd200
`define LEAD_NONE_MS 11'd0
`define LEAD_WARN_MS 11'd2
`define LEAD_SB_MS 11'd10

// Share bus.
`define SHARE_BITS 8
`define TRIM_MAX 5'd25

// Register offsets and fields.
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SHARE 8'h08
`define CTRL_PERMIT_BIT 0
`define CTRL_RESET 1'b0
`endif

// ===== design/supply_seq_pkg.sv
package supply_seq_pkg;
  typedef enum logic [1:0] {M_OFF, M_ON, M_WARN, M_REST} main_st_t;
  typedef enum logic [1:0] {SB_OFF, SB_ON, SB_REST} sb_st_t;
  typedef logic [1:0] htrans_t;
  typedef logic [10:0] ms_cnt_t;
endpackage

// ===== design/tick_if.sv
`timescale 1ns/100ps
interface tick_if;
  logic ms_tick;
  modport src (output ms_tick);
  modport snk (input ms_tick);
endinterface

// ===== design/ms_timebase.sv
`timescale 1ns/100ps
module ms_timebase #(
  parameter int unsigned CYC_PER_MS = 10000
) (
  input wire logic hclk,
  input wire logic hresetn,
  tick_if.src tk
);
  logic [15:0] div_q;

  // Divides the bus clock down to one pulse per millisecond.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 16'h0000;
      tk.ms_tick <= 1'b0;
    end else if (div_q == 16'(CYC_PER_MS - 1)) begin
      div_q <= 16'h0000;
      tk.ms_tick <= 1'b1;
    end else begin
      div_q <= div_q + 16'h0001;
      tk.ms_tick <= 1'b0;
    end
  end
endmodule

// ===== design/supply_output_sequencer.sv
`timescale 1ns/100ps
`include "supply_seq_map.svh"
module supply_output_sequencer #(
  parameter int unsigned CYC_PER_MS = `CYC_PER_MS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire supply_seq_pkg::htrans_t htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic inserted,
  input wire logic main_kill,
  input wire logic main_enable_n,
  input wire logic ac_in_range,
  input wire logic load_low,
  input wire logic overtemperature,
  input wire logic fan_fail,
  input wire logic standby_uv_ov,
  input wire logic main_oc_sw,
  input wire logic main_oc_hw,
  input wire logic main_ov,
  input wire logic sense_short,
  input wire logic [7:0] share_level,
  input wire logic share_bus_i,
  output logic share_bus_o,
  output logic share_bus_oe,
  input wire logic standby_permit_line_i,
  output logic standby_permit_line_o,
  output logic standby_permit_line_oe,
  output logic present_n_o,
  output logic present_n_oe,
  output logic power_good_o,
  output logic power_good_oe,
  output logic ac_good,
  output logic standby_en,
  output logic main_en,
  output logic [4:0] share_trim
);
  import supply_seq_pkg::*;

  tick_if tk ();
  ms_timebase #(.CYC_PER_MS(CYC_PER_MS)) u_timebase (
    .hclk(hclk),
    .hresetn(hresetn),
    .tk(tk.src)
  );
  logic tick;
  assign tick = tk.ms_tick;

  // Saturating millisecond count, so a long idle never wraps to zero.
  function automatic ms_cnt_t ms_inc(input ms_cnt_t c);
    return (c == 11'h7ff) ? c : c + 11'd1;
  endfunction

  // Every pin input except share_level passes two flops before any logic looks at it.
  logic [13:0] raw, s1_q, s2_q;
  assign raw = {inserted, main_kill, main_enable_n, ac_in_range, load_low,
                overtemperature, fan_fail, standby_uv_ov, main_oc_sw, main_oc_hw,
                main_ov, sense_short, share_bus_i, standby_permit_line_i};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 14'h0000;
      s2_q <= 14'h0000;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic ins_s, kill_s, en_n_s, ac_s, load_s, ot_s, fan_s, sbf_s;
  logic ocsw_s, ochw_s, ov_s, short_s, bus_s, line_s;
  assign {ins_s, kill_s, en_n_s, ac_s, load_s, ot_s, fan_s, sbf_s,
          ocsw_s, ochw_s, ov_s, short_s, bus_s, line_s} = s2_q;

  // AC good: start-up and dip delays differ, loss is filtered briefly.
  logic ac_good_q, ac_seen_q;
  ms_cnt_t acon_q, loss_q, acoff_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acon_q <= 11'd0;
      loss_q <= 11'd0;
      acoff_q <= 11'd0;
      ac_good_q <= 1'b0;
      ac_seen_q <= 1'b0;
    end else begin
      acon_q <= !ac_s ? 11'd0 : (tick ? ms_inc(acon_q) : acon_q);
      loss_q <= ac_s ? 11'd0 : (tick ? ms_inc(loss_q) : loss_q);
      acoff_q <= ac_good_q ? 11'd0 : (tick ? ms_inc(acoff_q) : acoff_q);
      if (ac_good_q && loss_q >= `ACOK_OFF_MS) begin
        ac_good_q <= 1'b0;
      end else if (acon_q >= (ac_seen_q ? `ACOK_ON_DIP_MS : `ACOK_ON_START_MS)) begin
        ac_good_q <= 1'b1;
        ac_seen_q <= 1'b1;
      end
    end
  end

  // Standby output: independent of the kill input.
  sb_st_t sb_q;
  ms_cnt_t sb_cnt_q;
  logic sb_on;
  assign sb_on = (sb_q == SB_ON);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sb_q <= SB_OFF;
      sb_cnt_q <= 11'd0;
    end else begin
      unique case (sb_q)
        SB_OFF: begin
          sb_cnt_q <= 11'd0;
          if (ac_good_q && !short_s) begin
            sb_q <= SB_ON;
          end
        end
        SB_ON: begin
          sb_cnt_q <= tick ? ms_inc(sb_cnt_q) : sb_cnt_q;
          if (short_s || (!ac_good_q && acoff_q >= `AC_SB_HOLD_MS)) begin
            sb_q <= SB_REST;
            sb_cnt_q <= 11'd0;
          end
        end
        SB_REST: begin
          sb_cnt_q <= tick ? ms_inc(sb_cnt_q) : sb_cnt_q;
          if (sb_cnt_q >= `OFF_REST_MS) begin
            sb_q <= SB_OFF;
          end
        end
        default: sb_q <= SB_OFF;
      endcase
    end
  end

  // Latched faults; the fault input wins over a clear in the same cycle.
  logic fault_q, fault_in, main_fault;
  assign main_fault = ocsw_s | ochw_s | ov_s;
  assign fault_in = main_fault | ot_s | fan_s | sbf_s | short_s;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_q <= 1'b0;
    end else if (fault_in) begin
      fault_q <= 1'b1;
    end else if (en_n_s) begin
      fault_q <= 1'b0;
    end
  end

  // Main output sequence. The enable input is active low; its pull-up
  // sits in the pad, so an open pin reads as disabled here too.
  logic run_ok;
  assign run_ok = sb_on && ac_good_q && !en_n_s && !kill_s && !fault_q;
  main_st_t m_q, m_d;
  ms_cnt_t m_cnt_q, lead_q, lead_d;
  always_comb begin
    m_d = m_q;
    lead_d = lead_q;
    unique case (m_q)
      M_OFF: begin
        if (run_ok && m_cnt_q >= `MAIN_ON_DLY_MS && sb_cnt_q >= `MAIN_ON_DLY_MS) begin
          m_d = M_ON;
        end
      end
      M_ON: begin
        if (kill_s || main_fault || !sb_on) begin
          m_d = M_REST;
        end else if (tick && (en_n_s || ot_s || fan_s)) begin // Tick aligned, so the lead is whole.
          m_d = M_WARN;
          lead_d = `LEAD_WARN_MS;
        end else if (tick && sbf_s) begin
          m_d = M_WARN;
          lead_d = `LEAD_SB_MS;
        end else if (tick && !ac_good_q && acoff_q >= `AC_MAIN_PRE_MS) begin
          m_d = M_WARN;
          lead_d = `LEAD_WARN_MS;
        end
      end
      M_WARN: begin
        if (kill_s || main_fault || m_cnt_q >= lead_q) begin
          m_d = M_REST;
        end
      end
      M_REST: begin
        if (m_cnt_q >= `OFF_REST_MS) begin
          m_d = M_OFF;
        end
      end
      default: m_d = M_OFF;
    endcase
  end

  // One counter shared by all states; it restarts on every state change and while M_OFF without run_ok.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      m_q <= M_OFF;
      m_cnt_q <= 11'd0;
      lead_q <= `LEAD_NONE_MS;
    end else begin
      m_q <= m_d;
      lead_q <= lead_d;
      if (m_d != m_q || (m_q == M_OFF && !run_ok)) begin
        m_cnt_q <= 11'd0;
      end else if (tick) begin
        m_cnt_q <= ms_inc(m_cnt_q);
      end
    end
  end

  // Hot standby: entered only while on, with pin, low load and permission.
  logic permit_q, hs_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_q <= 1'b0;
    end else if (m_q != M_ON || !line_s || fault_q || !permit_q) begin
      hs_q <= 1'b0;
    end else if (load_s) begin
      hs_q <= 1'b1;
    end
  end

  // Current share: bit-serial arbitration, one bit per millisecond, MSB
  // first. A one is dominant (pulls low), so the largest current wins.
  logic share_conn, lost_q, master_q, drive_bit;
  logic [2:0] bit_q;
  logic [7:0] level_q;
  logic [4:0] trim_q;
  assign share_conn = (m_q == M_ON) && !fault_q && !hs_q;
  assign drive_bit = share_conn && level_q[bit_q] && !lost_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_q <= 3'd7;
      level_q <= 8'h00;
      lost_q <= 1'b0;
      master_q <= 1'b0;
      trim_q <= 5'd0;
    end else if (!share_conn) begin
      bit_q <= 3'd7;
      level_q <= share_level;
      lost_q <= 1'b0;
      master_q <= 1'b0;
      trim_q <= 5'd0;
    end else if (tick) begin
      lost_q <= lost_q | (!drive_bit && !bus_s);
      if (bit_q == 3'd0) begin
        // The trim rises one step per frame while losing and drops to zero on a win, so a slave eases up gently.
        master_q <= !(lost_q | (!drive_bit && !bus_s));
        if (lost_q | (!drive_bit && !bus_s)) begin
          trim_q <= (trim_q < `TRIM_MAX) ? trim_q + 5'd1 : trim_q;
        end else begin
          trim_q <= 5'd0;
        end
        lost_q <= 1'b0;
        level_q <= share_level;
        bit_q <= 3'd7;
      end else begin
        bit_q <= bit_q - 3'd1;
      end
    end
  end

  // Pin enables and output drivers, all registered; pin data outputs tied low.
  logic pg_good;
  assign pg_good = (m_q == M_ON) && sb_on && m_cnt_q >= `PG_ON_MS
                   && m_d == M_ON;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      present_n_oe <= 1'b0;
      power_good_oe <= 1'b1;
      standby_permit_line_oe <= 1'b0;
      share_bus_oe <= 1'b0;
      ac_good <= 1'b0;
      standby_en <= 1'b0;
      main_en <= 1'b0;
      share_trim <= 5'd0;
    end else begin
      present_n_oe <= ins_s;
      power_good_oe <= !pg_good;
      standby_permit_line_oe <= fault_q;
      share_bus_oe <= drive_bit;
      ac_good <= ac_good_q;
      standby_en <= sb_on;
      main_en <= (m_q == M_ON || m_q == M_WARN) && !hs_q;
      share_trim <= trim_q;
    end
  end
  assign present_n_o = 1'b0;
  assign power_good_o = 1'b0;
  assign standby_permit_line_o = 1'b0;
  assign share_bus_o = 1'b0;

  // AHB-Lite slave: zero wait states, always OKAY, word registers.
  logic wr_q;
  logic [7:0] waddr_q;
  logic [31:0] rdata_q;
  logic take;
  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    unique case (a)
      `REG_CTRL: reg_read = {31'h00000000, permit_q};
      `REG_STATUS: reg_read = {22'h000000, m_q, hs_q, fault_q, !power_good_oe,
                               main_en, sb_on, ac_good_q, ins_s, master_q};
      `REG_SHARE: reg_read = {19'h00000, share_level, trim_q};
      default: reg_read = 32'h00000000;
    endcase
  endfunction

  // Write data lands in the data phase; reads capture state at address time.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
      rdata_q <= 32'h00000000;
      permit_q <= `CTRL_RESET;
    end else begin
      wr_q <= take && hwrite;
      waddr_q <= haddr[7:0];
      if (take && !hwrite) begin
        rdata_q <= reg_read(haddr[7:0]);
      end
      if (wr_q && waddr_q == `REG_CTRL) begin
        permit_q <= hwdata[`CTRL_PERMIT_BIT];
      end
    end
  end
endmodule

// ===== tb/supply_seq_props.sv
`timescale 1ns/100ps
module supply_seq_props #(
  parameter int unsigned CYC_PER_MS = 10
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic inserted,
  input wire logic main_kill,
  input wire logic main_enable_n,
  input wire logic ac_in_range,
  input wire logic load_low,
  input wire logic main_ov,
  input wire logic share_bus_oe,
  input wire logic standby_permit_line_oe,
  input wire logic present_n_oe,
  input wire logic power_good_oe,
  input wire logic ac_good,
  input wire logic standby_en,
  input wire logic main_en,
  input wire logic [4:0] share_trim
);
  localparam int L1 = CYC_PER_MS + 3;
  localparam int L5 = 5 * CYC_PER_MS;
  localparam int L20 = 20 * CYC_PER_MS + 3;
  localparam int L2K = 2000 * CYC_PER_MS + 3;
  logic [15:0] hi_q;
  logic [15:0] lo_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Saturating counts of how long the line has been in or out of range.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_q <= 16'h0;
      lo_q <= 16'h0;
    end else begin
      hi_q <= ac_in_range ? hi_q + 16'(hi_q != 16'hffff) : 16'h0;
      lo_q <= ac_in_range ? 16'h0 : lo_q + 16'(lo_q != 16'hffff);
    end
  end
  a_present_pin: assert property (inserted [*4] |-> present_n_oe)
    else $error("presence pin not pulled low");
  a_kill_main: assert property ($rose(main_kill) |-> ##[1:L1] !main_en && power_good_oe)
    else $error("kill did not drop main output");
  a_pg_first: assert property ($fell(main_en) && !load_low |-> power_good_oe)
    else $error("power good still high as main fell");
  a_pg_standby: assert property (!power_good_oe |-> standby_en)
    else $error("power good without standby output");
  a_ac_start: assert property (hi_q >= L2K |-> ac_good)
    else $error("ac good late");
  a_ac_loss: assert property (lo_q >= L5 |-> !ac_good)
    else $error("ac good still high after loss");
  a_enable_off: assert property ($rose(main_enable_n) |-> ##[1:L20] !main_en)
    else $error("main output not off after release");
  a_share_off: assert property (!main_en [*2] |-> !share_bus_oe)
    else $error("share bus driven while main off");
  a_trim_max: assert property (share_trim <= 5'd25)
    else $error("trim beyond limit");
  a_permit_fault: assert property ($rose(main_ov) |-> ##[1:L1] standby_permit_line_oe)
    else $error("fault did not pull permit line");
  a_main_cause: assert property ($rose(main_en) |-> ac_good && standby_en)
    else $error("main started without ac and standby");
  c_main_on: cover property ($rose(main_en));
  c_ac_lost: cover property ($fell(ac_good));
  c_kill: cover property ($rose(main_kill) ##[1:L1] !main_en);
endmodule

// ===== tb/pdu_model.sv
`timescale 1ns/100ps
module pdu_model #(
  parameter int unsigned CYC_PER_MS = 10
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic off_req,
  input wire logic kill_req,
  input wire logic power_good_oe,
  input wire logic share_bus_oe,
  input wire logic standby_permit_line_oe,
  output logic main_enable_n,
  output logic main_kill,
  output logic pg_wire,
  output logic share_wire,
  output logic permit_wire
);
  int hold_q;
  // Pulled-up lines read high unless a supply sinks them; only one supply here.
  assign pg_wire = !power_good_oe;
  assign share_wire = !share_bus_oe;
  assign permit_wire = !standby_permit_line_oe;
  // Enable goes high at once but is never lowered before the minimum high time.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_enable_n <= 1'b0;
      main_kill <= 1'b0;
      hold_q <= 0;
    end else begin
      main_kill <= kill_req;
      if (off_req) begin
        main_enable_n <= 1'b1;
        hold_q <= 10 * CYC_PER_MS;
      end else if (hold_q > 0) begin
        hold_q <= hold_q - 1;
      end else begin
        main_enable_n <= 1'b0;
      end
    end
  end
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import supply_seq_pkg::*;
  localparam int unsigned CYC_PER_MS = 10;
  localparam int MS = 10;
  localparam int AC = 0, SB = 1, MN = 2, PG = 3, PR = 4;
  logic hclk, hreadyout, hresp, main_kill, main_enable_n, pg_wire, share_wire, permit_wire;
  logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, inserted = 1'b0, ac_in_range = 1'b0;
  logic load_low = 1'b0, off_req = 1'b0, kill_req = 1'b0, hready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  htrans_t htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [6:0] flt = 7'h0;
  logic [7:0] lvl = 8'h40;
  logic share_bus_oe, standby_permit_line_oe, present_n_oe, power_good_oe;
  logic ac_good, standby_en, main_en;
  logic [4:0] share_trim;
  int errors = 0, n_compared = 0;
  assign hready = hreadyout;
  supply_output_sequencer #(.CYC_PER_MS(CYC_PER_MS)) supply_output_sequencer_i (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .inserted, .main_kill, .main_enable_n, .ac_in_range, .load_low, .overtemperature(flt[0]),
    .fan_fail(flt[1]), .standby_uv_ov(flt[2]), .main_oc_sw(flt[3]), .main_oc_hw(flt[4]),
    .main_ov(flt[5]), .sense_short(flt[6]), .share_level(lvl), .share_bus_i(share_wire),
    .share_bus_o(), .share_bus_oe, .standby_permit_line_i(permit_wire),
    .standby_permit_line_o(), .standby_permit_line_oe, .present_n_o(), .present_n_oe,
    .power_good_o(), .power_good_oe, .ac_good, .standby_en, .main_en, .share_trim);
  pdu_model #(.CYC_PER_MS(CYC_PER_MS)) pdu_model_i (.hclk, .hresetn, .off_req, .kill_req,
    .power_good_oe, .share_bus_oe, .standby_permit_line_oe, .main_enable_n, .main_kill,
    .pg_wire, .share_wire, .permit_wire);
  // The clock runs free at 10 MHz.
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic results;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rng(input string what, input int n, input int lo, input int hi);
    n_compared++;
    if (n < lo || n > hi) begin
      errors++;
      $display("mismatch %s expected %0d to %0d seen %0d", what, lo, hi, n);
    end
  endtask
  function automatic logic sig(input int s);
    case (s)
      AC: return ac_good;
      SB: return standby_en;
      MN: return main_en;
      PG: return pg_wire;
      default: return present_n_oe;
    endcase
  endfunction
  // Samples on the falling edge, where registered outputs have settled.
  task automatic wt(input int s, input logic v, input int lim, output int n);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (sig(s) !== v && n < lim);
    n_compared++;
    if (sig(s) !== v) begin
      errors++;
      $display("mismatch pin %0d expected %b seen %b", s, v, sig(s));
      results();
    end
  endtask
  // One single word transfer; the address phase is held until ready is seen.
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    k = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 40);
    r = hrdata;
    if (k >= 40) begin
      errors++;
      $display("mismatch bus ready expected 1 seen %b", hready);
      results();
    end
  endtask
  task automatic t_regs;
    logic [31:0] r;
    ahb(1'b0, 32'h0, 32'h0, r);
    chk("ctrl reset", 32'h0, r);
    ahb(1'b1, 32'h0, 32'h1, r);
    ahb(1'b0, 32'h0, 32'h0, r);
    chk("ctrl permit", 32'h1, r);
    ahb(1'b1, 32'h0, 32'h0, r);
    ahb(1'b1, 32'h0c, 32'hffffffff, r);
    ahb(1'b0, 32'h0c, 32'h0, r);
    chk("unmapped", 32'h0, r);
    chk("bus response", 32'h0, {31'h0, hresp});
  endtask
  task automatic t_start;
    int n;
    logic [31:0] r;
    @(posedge hclk);
    inserted <= 1'b1;
    ac_in_range <= 1'b1;
    wt(PR, 1'b1, 10, n);
    wt(AC, 1'b1, 2000 * MS, n);
    wt(SB, 1'b1, MS, n);
    wt(MN, 1'b1, 500 * MS, n);
    rng("main after standby", n, 10 * MS, 500 * MS);
    wt(PG, 1'b1, 500 * MS, n);
    rng("pg after main", n, 100 * MS, 500 * MS);
    ahb(1'b0, 32'h04, 32'h0, r);
    chk("status on", 32'h0000013f, r);
    ahb(1'b0, 32'h08, 32'h0, r);
    chk("share reg", 32'h00000800, r);
    chk("trim", 32'h0, {27'h0, share_trim});
  endtask
  task automatic t_hot;
    logic [31:0] r;
    int n;
    @(posedge hclk);
    load_low <= 1'b1;
    ahb(1'b1, 32'h0, 32'h1, r);
    wt(MN, 1'b0, 50 * MS, n);
    chk("pg in hot standby", 32'h1, {31'h0, pg_wire});
    ahb(1'b1, 32'h0, 32'h0, r);
    wt(MN, 1'b1, 1300 * MS, n);
    @(posedge hclk);
    load_low <= 1'b0;
  endtask
  task automatic t_kill;
    int n;
    @(posedge hclk);
    kill_req <= 1'b1;
    wt(MN, 1'b0, MS + 3, n);
    chk("pg on kill", 32'h0, {31'h0, pg_wire});
    chk("standby on kill", 32'h1, {31'h0, standby_en});
    @(posedge hclk);
    kill_req <= 1'b0;
    wt(MN, 1'b1, 1300 * MS, n);
    rng("main off time", n, 1000 * MS, 1200 * MS);
    wt(PG, 1'b1, 500 * MS, n);
  endtask
  task automatic t_enable;
    int n;
    @(posedge hclk);
    off_req <= 1'b1;
    @(posedge hclk);
    off_req <= 1'b0;
    wt(MN, 1'b0, 25 * MS, n);
    rng("main off delay", n, 2 * MS, 20 * MS);
    wt(MN, 1'b1, 1300 * MS, n);
    wt(PG, 1'b1, 500 * MS, n);
  endtask
  task automatic t_fault;
    int n;
    @(posedge hclk);
    flt[5] <= 1'b1;
    wt(MN, 1'b0, 3 * MS, n);
    wt(PG, 1'b0, 1, n);
    chk("permit line", 32'h0, {31'h0, permit_wire});
    @(posedge hclk);
    flt[5] <= 1'b0;
    repeat (1250 * MS) @(negedge hclk);
    chk("fault latched", 32'h0, {31'h0, main_en});
    @(posedge hclk);
    off_req <= 1'b1;
    @(posedge hclk);
    off_req <= 1'b0;
    wt(MN, 1'b1, 100 * MS, n);
    rng("main on delay", n - 10 * MS - 1, 2 * MS, 20 * MS);
    wt(PG, 1'b1, 500 * MS, n);
  endtask
  task automatic t_acloss;
    int n;
    int k;
    @(posedge hclk);
    ac_in_range <= 1'b0;
    wt(AC, 1'b0, 5 * MS, n);
    wt(MN, 1'b0, 100 * MS, n);
    rng("main holdup", n, 7 * MS, 100 * MS);
    wt(SB, 1'b0, 100 * MS, k);
    rng("standby holdup", n + k, 15 * MS, 100 * MS);
    @(posedge hclk);
    ac_in_range <= 1'b1;
    wt(AC, 1'b1, 100 * MS, n);
  endtask
  // A sense short must take both outputs down once they are back up.
  task automatic t_short;
    int n;
    wt(SB, 1'b1, 1300 * MS, n);
    wt(MN, 1'b1, 100 * MS, n);
    @(posedge hclk);
    flt[6] <= 1'b1;
    wt(SB, 1'b0, MS, n);
    wt(MN, 1'b0, MS, n);
  endtask
  // Reset for 20 cycles, then the scenarios in order.
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_start();
    t_hot();
    t_kill();
    t_enable();
    t_fault();
    t_acloss();
    t_short();
    results();
  end
endmodule
bind supply_output_sequencer supply_seq_props #(.CYC_PER_MS(CYC_PER_MS)) props_i (.hclk,
  .hresetn, .inserted, .main_kill, .main_enable_n, .ac_in_range, .load_low, .main_ov,
  .share_bus_oe, .standby_permit_line_oe, .present_n_oe, .power_good_oe, .ac_good,
  .standby_en, .main_en, .share_trim);
